/* bench/ctsr_host.sv */
// host model that issues register requests and collects the answers
module ctsr_host (
  input  wire logic                clk_sys_in,  // system clock
  input  wire ctsr_pkg::ctsr_rsp_t rsp_in,      // register answer
  output ctsr_pkg::ctsr_req_t      req_out      // register request
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_out = '0;
  // ==========
  // one strobe; a released bus shows inverted values so stale data never matches
  // rerunning a low-current test is left to the caller
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output ctsr_pkg::ctsr_rsp_t r);
    @(posedge clk_sys_in) #1;
    req_out = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk_sys_in) #1;
    req_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    r = rsp_in;  // answer stands one cycle after the taking edge
  endtask
endmodule

/* bench/ctsr_top_tb.sv */
// self-checking bench of the telemetry status register bank
`include "ctsr_regs.svh"
module ctsr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, ibv = 0, bsr = 0, chg = 1, men = 0;  // drivers
  logic signed [15:0] ib = '0;                                 // battery sample
  logic [7:0] mcode = 8'h00, uvs = 8'h00;                      // uv sources
  logic chg_en, tv;                                            // design outputs
  ctsr_pkg::ctsr_req_t req;                                    // request bus
  ctsr_pkg::ctsr_rsp_t rsp;                                    // answer bus
  int n_errors = 0, samples_checked = 0;                       // counters
  logic signed [15:0] tbl [4] = '{16'sd2183, 16'sd2184, -16'sd5, 16'sh7fff};
  initial forever #5 clk = ~clk;
  ctsr_top #(.WARMUP_CYCLES(20)) DUT (.clk_sys_in(clk), .reset_in(rst), .req_in(req),
    .rsp_out(rsp), .ibat_in(ib), .ibat_valid_in(ibv), .bsr_meas_in(bsr),
    .charger_en_req_in(chg), .mppt_en_in(men), .mppt_code_in(mcode),
    .uv_setting_in(uvs), .charge_en_out(chg_en), .telem_valid_out(tv));
  ctsr_host host (.clk_sys_in(clk), .rsp_in(rsp), .req_out(req));
  // ==========
  task automatic check(input logic [17:0] s, input logic [17:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // read expects valid, hit and data; write expects no answer at all
  task automatic rd(input logic [7:0] a, input logic h, input logic [15:0] e);
    ctsr_pkg::ctsr_rsp_t r;
    host.xfer(1'b0, a, 16'h0000, r);
    check({r.valid, r.hit, r.rdata}, {1'b1, h, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    ctsr_pkg::ctsr_rsp_t r;
    host.xfer(1'b1, a, d, r);
    check({17'h0, r.valid}, 18'h0);
  endtask
  // sample pulse, then test pulse one cycle later
  task automatic capt(input logic signed [15:0] s);
    @(posedge clk) #1;
    ib = s;
    ibv = 1;
    @(posedge clk) #1;
    ibv = 0;
    bsr = 1;
    @(posedge clk) #1;
    bsr = 0;
    ib = ~s;
  endtask
  // ==========
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    rd(`CTSR_ADDR_RT_CURRENT, 1, 16'h0);
    rd(`CTSR_ADDR_TELEM_STATUS, 1, 16'h0);
    rd(`CTSR_ADDR_UV_CODE, 1, 16'h0);
    rd(8'h49, 0, 16'h0);
    check({17'h0, chg_en}, 18'h0);
    $display("test reset done");
    for (int i = 0; i < 40 && tv !== 1'b1; i++) @(posedge clk) #1;
    check({17'h0, tv}, 18'h1);
    if (tv !== 1'b1) wrap_up();
    @(posedge clk) #1;
    check({17'h0, chg_en}, 18'h1);
    rd(`CTSR_ADDR_TELEM_STATUS, 1, 16'h1);
    $display("test warmup done");
    foreach (tbl[i])
    begin
      capt(tbl[i]);
      rd(`CTSR_ADDR_RT_CURRENT, 1, tbl[i]);
      rd(`CTSR_ADDR_TELEM_STATUS, 1, {14'h0, tbl[i] < `CTSR_ICHARGE_OVER_10, 1'b1});
    end
    wr(`CTSR_ADDR_RT_CURRENT, 16'h1234);
    wr(`CTSR_ADDR_TELEM_STATUS, 16'h0000);
    rd(`CTSR_ADDR_RT_CURRENT, 1, 16'h7fff);
    rd(`CTSR_ADDR_TELEM_STATUS, 1, 16'h1);
    $display("test capture done");
    uvs = 8'h5a;
    mcode = 8'ha5;
    rd(`CTSR_ADDR_UV_CODE, 1, 16'h005a);
    men = 1;
    rd(`CTSR_ADDR_UV_CODE, 1, 16'h00a5);
    $display("test uv code done");
    chg = 0;
    @(posedge clk) #1;
    check({17'h0, chg_en}, 18'h0);
    chg = 1;
    @(posedge clk) #1;
    check({17'h0, chg_en}, 18'h1);
    capt(16'sh0010);
    rst = 1;
    repeat (2) @(posedge clk) #1;
    rst = 0;
    check({17'h0, tv}, 18'h0);
    check({17'h0, chg_en}, 18'h0);
    rd(`CTSR_ADDR_RT_CURRENT, 1, 16'h0);
    rd(`CTSR_ADDR_TELEM_STATUS, 1, 16'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule

/* src/ctsr_pkg.sv */
// types shared by the telemetry status bank
package ctsr_pkg;
  // one register read request and its answer
  typedef struct packed {
    logic       rd;       // read strobe
    logic       wr;       // write strobe, ignored
    logic [7:0] addr;     // command code
    logic [15:0] wdata;   // write data, ignored
  } ctsr_req_t;
  typedef struct packed {
    logic        valid;   // read data valid pulse
    logic        hit;     // address was mapped
    logic [15:0] rdata;   // read data
  } ctsr_rsp_t;
endpackage

/* src/ctsr_regs.svh */
// register offsets, field positions, reset values and timing counts of the telemetry status bank
`ifndef CTSR_REGS_SVH
`define CTSR_REGS_SVH
`define CTSR_ADDR_RT_CURRENT    8'h48
`define CTSR_ADDR_TELEM_STATUS  8'h4a
`define CTSR_ADDR_UV_CODE       8'h4b
`define CTSR_BIT_TELEM_VALID    0
`define CTSR_BIT_QUESTIONABLE   1
`define CTSR_RST_RT_CURRENT     16'h0000
`define CTSR_RST_TELEM_STATUS   2'h0
`define CTSR_RST_UV_CODE        8'h00
`define CTSR_ICHARGE_OVER_10    16'sd2184
`define CTSR_WARMUP_MS          12
`define CTSR_CLK_MHZ            100
`define CTSR_WARMUP_CYCLES      (`CTSR_WARMUP_MS * 1000 * `CTSR_CLK_MHZ)
`define CTSR_UV_STEP_UV         140625
`define CTSR_IBAT_STEP_NV       1466
`endif

/* src/ctsr_top.sv */
// charger telemetry status register bank
//
// Overview of operation
// - hold battery current seen at resistance test
// - captured current scaled like battery current
// - low current test sets questionable flag
// - questionable flag is status bit one
// - status bit zero set after warm-up
// - charging held off until telemetry valid
// - expose read-only 8-bit undervoltage code
// - tracking algorithm writes undervoltage code
// - otherwise code follows programmed setting
// - battery current negative when charger off
//
// notes for whoever picks this block up next
// - the bank is read only: a write strobe is taken and dropped, it
//   never raises an answer and never touches a register
// - every read is answered exactly one cycle after its taking edge,
//   with valid high for that single cycle; back to back reads are
//   fine and each gets its own answer pulse
// - read data is the register value as it stood at the taking edge,
//   so a capture and a read on the same edge shows the older value
// - an unmapped command code still answers, with hit low and zero
//   data, so the host never waits on a code that nobody decodes
// - the battery sample is stored raw; the scaling to amperes lives
//   in the host, which knows the battery_sense_resistor value
// - the questionable flag reflects only the last resistance test;
//   a test at good current clears it, there is no host clear
// - warm-up is a plain counter; simulation shortens it through the
//   parameter, otherwise a run would need over a million clocks
// - charging is gated by the registered valid bit, which costs one
//   cycle of latency on the enable but keeps the output glitch free
// - the undervoltage code is resampled every cycle from whichever
//   source is selected, so a switch of source shows one cycle later
//
`include "ctsr_regs.svh"
module ctsr_top #(
  parameter int unsigned WARMUP_CYCLES = `CTSR_WARMUP_CYCLES  // warm-up clocks, shorten in sim
) (
  input  wire logic               clk_sys_in,        // 100 MHz system clock
  input  wire logic               reset_in,          // sync reset, high
  input  wire ctsr_pkg::ctsr_req_t req_in,           // register request
  output ctsr_pkg::ctsr_rsp_t     rsp_out,           // register answer
  input  wire logic signed [15:0] ibat_in,           // battery current sample
  input  wire logic               ibat_valid_in,     // new battery sample pulse
  input  wire logic               bsr_meas_in,       // resistance test taken pulse
  input  wire logic               charger_en_req_in, // charge request from state machine
  input  wire logic               mppt_en_in,        // tracking enabled
  input  wire logic [7:0]         mppt_code_in,      // tracking code
  input  wire logic [7:0]         uv_setting_in,     // programmed undervoltage setting
  output logic                    charge_en_out,     // charging allowed
  output logic                    telem_valid_out    // warm-up elapsed
);
  // ==========================================================
  // state
  typedef struct packed {
    logic signed [15:0] ibat;      // latest battery sample
    logic signed [15:0] rt_cur;    // current at resistance test
    logic        [1:0]  status;    // questionable, valid
    logic        [7:0]  uv_code;   // regulation code
    logic               charge_en; // charge enable output
    ctsr_pkg::ctsr_rsp_t rsp;      // bus answer
  } ctsr_st_t;
  ctsr_st_t st_r, st_nxt;
  logic       warm_done;  // warm-up elapsed
  logic [7:0] uv_sel;     // selected code
  // ==========================================================
  // helpers
  ctsr_warmup #(.CYCLES(WARMUP_CYCLES)) u_warmup (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .done_out   (warm_done)
  );
  ctsr_uv_select u_uv (
    .mppt_en_in   (mppt_en_in),
    .mppt_code_in (mppt_code_in),
    .setting_in   (uv_setting_in),
    .code_out     (uv_sel)
  );
  // ==========================================================
  // next state
  //
  // capture timing, one cycle a line:
  //   c0  sample strobe high, new battery sample on the input
  //   c1  sample held in state; test strobe may fire here
  //   c2  captured current and questionable flag updated
  // the capture reads the held sample, not the input, so a test
  // strobe never races a sample arriving in the same cycle
  //
  // read timing, one cycle a line:
  //   c0  read strobe and command code taken
  //   c1  answer stands with valid high
  //   c2  valid low again unless another read was taken at c1
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rsp = '0;
    // sample keeps its sign, negative is battery drain
    if (ibat_valid_in)
      st_nxt.ibat = ibat_in;
    // capture current at test in native scaling, no rescale
    if (bsr_meas_in)
    begin
      st_nxt.rt_cur = st_r.ibat;
      st_nxt.status[`CTSR_BIT_QUESTIONABLE] = (st_r.ibat < `CTSR_ICHARGE_OVER_10);
    end
    st_nxt.status[`CTSR_BIT_TELEM_VALID] = warm_done;
    // charge held off until offsets have nulled
    st_nxt.charge_en = charger_en_req_in & st_r.status[`CTSR_BIT_TELEM_VALID];
    st_nxt.uv_code = uv_sel;
    // reads answer next cycle; writes change nothing
    if (req_in.rd)
    begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.hit = 1'b1;
      case (req_in.addr)
        `CTSR_ADDR_RT_CURRENT:   st_nxt.rsp.rdata = st_r.rt_cur;
        `CTSR_ADDR_TELEM_STATUS: st_nxt.rsp.rdata = {14'h0000, st_r.status};
        `CTSR_ADDR_UV_CODE:      st_nxt.rsp.rdata = {8'h00, st_r.uv_code};
        default:                 st_nxt.rsp.hit = 1'b0;
      endcase
    end
  end
  // ==========================================================
  // registers, everything zero from reset
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign rsp_out         = st_r.rsp;
  assign charge_en_out   = st_r.charge_en;
  assign telem_valid_out = st_r.status[`CTSR_BIT_TELEM_VALID];
  // ==========================================================
  // checks
  chk_charge_needs_valid: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    charge_en_out |-> $past(telem_valid_out)) else $error("charge before valid");
  chk_capture_value: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    bsr_meas_in |=> st_r.rt_cur == $past(st_r.ibat)) else $error("capture wrong");
  chk_questionable_set: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (bsr_meas_in && st_r.ibat < `CTSR_ICHARGE_OVER_10) |=> st_r.status[1])
    else $error("flag not set");
  chk_questionable_clr: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (bsr_meas_in && st_r.ibat >= `CTSR_ICHARGE_OVER_10) |=> !st_r.status[1])
    else $error("flag set");
  chk_uv_tracking: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    mppt_en_in |=> st_r.uv_code == $past(mppt_code_in)) else $error("uv not tracking");
  chk_uv_setting: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !mppt_en_in |=> st_r.uv_code == $past(uv_setting_in)) else $error("uv not setting");
  chk_valid_sticky: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    telem_valid_out |=> telem_valid_out) else $error("valid dropped");
  chk_write_ignored: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (req_in.wr && !bsr_meas_in) |=> $stable(st_r.rt_cur)) else $error("write changed");
  chk_read_answer: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    req_in.rd |=> rsp_out.valid ##1 (!rsp_out.valid || $past(req_in.rd)))
    else $error("no answer");

  // ==========================================================
  // read data checks
  // each mapped code must return the register as it stood at the
  // taking edge; comparing against the state one cycle back catches
  // a decode that reads the next-state copy by mistake
  chk_read_rt_data: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (req_in.rd && req_in.addr == `CTSR_ADDR_RT_CURRENT)
    |=> rsp_out.rdata == $past(st_r.rt_cur))
    else $error("rt current read wrong");

  // status reads carry the two flags in the low bits, zeros above
  chk_read_status_data: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (req_in.rd && req_in.addr == `CTSR_ADDR_TELEM_STATUS)
    |=> rsp_out.rdata == {14'h0000, $past(st_r.status)})
    else $error("status read wrong");

  // the regulation code sits in the low byte, zeros above
  chk_read_uv_data: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (req_in.rd && req_in.addr == `CTSR_ADDR_UV_CODE)
    |=> rsp_out.rdata == {8'h00, $past(st_r.uv_code)})
    else $error("uv code read wrong");

  // mapped codes must flag a hit so the host can trust the data
  chk_read_mapped_hit: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (req_in.rd && (req_in.addr == `CTSR_ADDR_RT_CURRENT
                   || req_in.addr == `CTSR_ADDR_TELEM_STATUS
                   || req_in.addr == `CTSR_ADDR_UV_CODE))
    |=> (rsp_out.valid && rsp_out.hit))
    else $error("mapped read missed");

  // unmapped codes still answer, but with no hit and zero data,
  // so stale register contents never leak through a bad code
  chk_read_unmapped: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (req_in.rd && req_in.addr != `CTSR_ADDR_RT_CURRENT
               && req_in.addr != `CTSR_ADDR_TELEM_STATUS
               && req_in.addr != `CTSR_ADDR_UV_CODE)
    |=> (rsp_out.valid && !rsp_out.hit && rsp_out.rdata == 16'h0000))
    else $error("unmapped read answered");

  // no read taken means no answer, writes included
  chk_no_spurious_answer: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !req_in.rd |=> !rsp_out.valid)
    else $error("answer without read");

  // ==========================================================
  // capture and flag checks
  // a new sample is latched only on its strobe, and held otherwise;
  // the sign must survive, since negative means battery drain
  chk_sample_latch: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    ibat_valid_in |=> st_r.ibat == $past(ibat_in))
    else $error("sample not latched");

  chk_sample_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !ibat_valid_in |=> $stable(st_r.ibat))
    else $error("sample moved");

  // the captured current only moves on a resistance test
  chk_capture_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !bsr_meas_in |=> $stable(st_r.rt_cur))
    else $error("capture moved");

  // the questionable flag describes the last test only, so it must
  // not drift between tests
  chk_flag_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !bsr_meas_in |=> $stable(st_r.status[`CTSR_BIT_QUESTIONABLE]))
    else $error("flag moved");

  // a host write aimed at the status must not disturb the flag
  chk_status_write_ignored: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (req_in.wr && !bsr_meas_in) |=> $stable(st_r.status[`CTSR_BIT_QUESTIONABLE]))
    else $error("status write changed");

  // ==========================================================
  // warm-up and charge gating checks
  // valid follows the timer one cycle later and never runs ahead
  chk_valid_follows_timer: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    warm_done |=> telem_valid_out)
    else $error("valid late");

  chk_valid_not_early: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !warm_done |=> !telem_valid_out)
    else $error("valid early");

  // once valid, a charge request must come through one cycle later
  chk_charge_follows_req: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (charger_en_req_in && telem_valid_out) |=> charge_en_out)
    else $error("charge not enabled");

  // dropping the request must drop charging one cycle later
  chk_charge_drops: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !charger_en_req_in |=> !charge_en_out)
    else $error("charge not dropped");

  // ==========================================================
  // reset check
  // no disable here: this one watches the reset itself; every
  // output, the captured current and the status must be zero on the edge after reset
  chk_reset_zero: assert property (@(posedge clk_sys_in)
    reset_in |=> (rsp_out == '0 && !charge_en_out && !telem_valid_out
                  && st_r.rt_cur == 16'h0000 && st_r.status == 2'h0))
    else $error("reset not zero");
endmodule

/* src/ctsr_uv_select.sv */
// picks the undervoltage regulation code from tracking or the programmed setting
module ctsr_uv_select (
  input  wire logic       mppt_en_in,    // tracking enabled
  input  wire logic [7:0] mppt_code_in,  // tracking algorithm code
  input  wire logic [7:0] setting_in,    // programmed setting
  output logic [7:0]      code_out       // selected code
);
  // tracking writes directly, otherwise follow setting
  assign code_out = mppt_en_in ? mppt_code_in : setting_in;
endmodule

/* src/ctsr_warmup.sv */
// warm-up timer that raises telemetry valid after the autozero interval
`include "ctsr_regs.svh"
module ctsr_warmup #(
  parameter int unsigned CYCLES = `CTSR_WARMUP_CYCLES  // warm-up length in clocks
) (
  input  wire logic clk_sys_in,  // system clock
  input  wire logic reset_in,    // sync reset, high
  output logic      done_out     // warm-up elapsed, level
);
  typedef struct packed {
    logic [31:0] cnt;  // cycles counted
    logic        done; // interval passed
  } ctsr_wu_t;
  ctsr_wu_t st_r, st_nxt;
  // count up once, then hold done
  always_comb
  begin
    st_nxt = st_r;
    if (!st_r.done)
    begin
      st_nxt.cnt = st_r.cnt + 32'h1;
      if (st_r.cnt >= CYCLES - 1)
        st_nxt.done = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign done_out = st_r.done;
endmodule
